// File: rtl/basic_mode_status_register.sv
// Summary of operation
// - Speed and duplex ability bits read one
// - Extended status present bit reads one
// - Preamble suppression bit one, preambleless frames decoded
// - Negotiation done bit follows negotiation state
// - SGMII: loss of signal or lock sets fault
// - 1000BASE-X: nonzero partner fault code sets fault
// - Fault latched; read clears only without fault
// - Link latched low; read restores if up
// - Interrupt mirrors of fault and link bits
// - Negotiation able and extended registers bits one
// - Writes leave read-only status unchanged
// - Status register reachable regardless of page
`include "status_map.svh"

module basic_mode_status_register
    import status_pkg::*;
#(
    parameter int DATA_W = `DATA_BITS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Management serial interface
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_address,
    // Line status
    input wire logic sgmii_mode,
    input wire logic loss_of_signal_in,
    input wire logic cdr_lock_lost,
    input wire logic [15:0] partner_ability_word,
    input wire logic pcs_link_up,
    input wire logic negotiation_done_in,
    // Interrupt register mirrors
    input wire logic fault_irq_enable,
    input wire logic link_irq_enable,
    output logic fault_mirror,
    output logic link_mirror,
    output logic status_irq
);

    generate
        if (DATA_W != 16) begin : g_bad_width
            $error("DATA_W must be 16");
        end
    endgenerate

    mdio_state_e state_q;
    mdio_state_e state_d;
    logic mdc_q;
    logic mdc_d;
    logic mdc_rise;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [1:0] op_q;
    logic [1:0] op_d;
    logic [9:0] addr_q;
    logic [9:0] addr_d;
    logic hit_q;
    logic hit_d;
    status_word_t shift_q;
    status_word_t shift_d;
    status_word_t word_q;
    status_word_t word_d;
    logic out_d;
    logic oe_d;
    logic read_pulse;
    logic far_end_fault_latch;
    logic link_up_latch;
    logic fault_mirror_d;
    logic link_mirror_d;
    logic irq_d;

    function automatic status_word_t status_word(input logic done, input logic fault, input logic link);
        status_word_t w;
        w = `STATUS_RESET;
        w[`FAST_FD_BIT] = 1'b1;
        w[`FAST_HD_BIT] = 1'b1;
        w[`TEN_FD_BIT] = 1'b1;
        w[`TEN_HD_BIT] = 1'b1;
        w[`EXT_STATUS_BIT] = 1'b1;
        w[`PREAMBLE_SUP_BIT] = 1'b1;
        w[`NEG_DONE_BIT] = done;
        w[`FAULT_BIT] = fault;
        w[`NEG_ABLE_BIT] = 1'b1;
        w[`LINK_BIT] = link;
        w[`EXT_REGS_BIT] = 1'b1;
        return w;
    endfunction

    status_latches u_latches (
        .clock(clock),
        .resetn(resetn),
        .sgmii_mode(sgmii_mode),
        .loss_of_signal_in(loss_of_signal_in),
        .cdr_lock_lost(cdr_lock_lost),
        .partner_ability_word(partner_ability_word),
        .pcs_link_up(pcs_link_up),
        .read_pulse(read_pulse),
        .far_end_fault_latch(far_end_fault_latch),
        .link_up_latch(link_up_latch)
    );

    // Management frame engine, one step per rising edge of mdc
    always_comb begin
        mdc_d = mdc;
        mdc_rise = mdc & ~mdc_q;
        state_d = state_q;
        cnt_d = cnt_q;
        op_d = op_q;
        addr_d = addr_q;
        hit_d = hit_q;
        shift_d = shift_q;
        word_d = word_q;
        out_d = mdio_out;
        oe_d = mdio_oe;
        read_pulse = 1'b0;
        if (mdc_rise) begin
            case (state_q)
                S_IDLE: begin
                    // Any run of ones is preamble; a zero starts the frame
                    if (!mdio_in) begin
                        state_d = S_START;
                    end
                end
                S_START: begin
                    cnt_d = 4'h0;
                    state_d = mdio_in ? S_OPCODE : S_IDLE;
                end
                S_OPCODE: begin
                    op_d = {op_q[0], mdio_in};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `OP_LAST) begin
                        cnt_d = 4'h0;
                        state_d = S_ADDRESS;
                    end
                end
                S_ADDRESS: begin
                    addr_d = {addr_q[8:0], mdio_in};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `ADDR_LAST) begin
                        cnt_d = 4'h0;
                        state_d = S_TURN;
                    end
                end
                S_TURN: begin
                    if (cnt_q == 4'h0) begin
                        cnt_d = 4'h1;
                        // No page select here, so address 1 decodes on every page
                        hit_d = (op_q == `OP_READ) && (addr_q[9:5] == phy_address);
                        if (hit_d) begin
                            oe_d = 1'b1;
                            out_d = 1'b0;
                            if (addr_q[4:0] == `BLS_REG_ADDR) begin
                                word_d = status_word(negotiation_done_in, far_end_fault_latch, link_up_latch);
                                read_pulse = 1'b1;
                            end else begin
                                word_d = `STATUS_RESET;
                            end
                            shift_d = word_d;
                        end
                    end else begin
                        cnt_d = 4'h0;
                        state_d = S_DATA;
                        if (hit_q) begin
                            out_d = shift_q[15];
                            shift_d = {shift_q[14:0], 1'b0};
                        end
                    end
                end
                S_DATA: begin
                    // Write data is clocked through and discarded
                    if (cnt_q == `DATA_LAST) begin
                        state_d = S_IDLE;
                        cnt_d = 4'h0;
                        hit_d = 1'b0;
                        oe_d = 1'b0;
                        out_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                        if (hit_q) begin
                            out_d = shift_q[15];
                            shift_d = {shift_q[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            mdc_q <= 1'b0;
            cnt_q <= 4'h0;
            op_q <= 2'h0;
            addr_q <= 10'h000;
            hit_q <= 1'b0;
            shift_q <= `STATUS_RESET;
            word_q <= `STATUS_RESET;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            state_q <= state_d;
            mdc_q <= mdc_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            addr_q <= addr_d;
            hit_q <= hit_d;
            shift_q <= shift_d;
            word_q <= word_d;
            mdio_out <= out_d;
            mdio_oe <= oe_d;
        end
    end

    // Interrupt register mirrors
    always_comb begin
        fault_mirror_d = far_end_fault_latch;
        link_mirror_d = link_up_latch;
        irq_d = (fault_irq_enable & far_end_fault_latch) | (link_irq_enable & ~link_up_latch);
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            fault_mirror <= 1'b0;
            link_mirror <= 1'b0;
            status_irq <= 1'b0;
        end else begin
            fault_mirror <= fault_mirror_d;
            link_mirror <= link_mirror_d;
            status_irq <= irq_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_speed_bits: assert property (read_pulse |=> word_q[14:11] == 4'hF)
        else $error("Speed ability bits not all one");
    chk_ext_status: assert property (read_pulse |=> word_q[8])
        else $error("Extended status bit not one");
    chk_preamble_free: assert property (state_q == S_IDLE && mdc_rise && !mdio_in |=> state_q == S_START)
        else $error("Frame without preamble not started");
    chk_negot_done: assert property (read_pulse |=> word_q[5] == $past(negotiation_done_in))
        else $error("Negotiation done bit wrong");
    chk_fault_value: assert property (read_pulse |=> word_q[4] == $past(far_end_fault_latch))
        else $error("Fault bit read wrong value");
    chk_link_value: assert property (read_pulse |=> word_q[2] == $past(link_up_latch))
        else $error("Link bit read wrong value");
    chk_irq_mirror: assert property (##1 status_irq == $past(irq_d) &&
        fault_mirror == $past(far_end_fault_latch) && link_mirror == $past(link_up_latch))
        else $error("Interrupt mirror wrong");
    chk_ext_bits: assert property (read_pulse |=> word_q[3] && word_q[0])
        else $error("Ability or extended register bit not one");
    chk_write_ignored: assert property (op_q == `OP_WRITE && state_q == S_DATA |-> !mdio_oe && !read_pulse)
        else $error("Write frame drove the line or read status");
    chk_any_page: assert property (read_pulse |->
        addr_q[4:0] == `BLS_REG_ADDR && addr_q[9:5] == phy_address)
        else $error("Status read on wrong address");
    chk_reserved_zero: assert property (read_pulse |=> (word_q & 16'h8682) == 16'h0000)
        else $error("Reserved bits not zero");
    chk_turn_zero: assert property (read_pulse |=> mdio_oe && !mdio_out)
        else $error("Turnaround zero not driven");

endmodule

// File: rtl/status_map.svh
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// Register address and management frame layout
`define BLS_REG_ADDR 5'h01
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define DATA_BITS 16
`define OP_LAST 4'h1
`define ADDR_LAST 4'h9
`define DATA_LAST 4'hF

// Field positions of the basic link status register
`define FAST_FD_BIT 14
`define FAST_HD_BIT 13
`define TEN_FD_BIT 12
`define TEN_HD_BIT 11
`define EXT_STATUS_BIT 8
`define PREAMBLE_SUP_BIT 6
`define NEG_DONE_BIT 5
`define FAULT_BIT 4
`define NEG_ABLE_BIT 3
`define LINK_BIT 2
`define EXT_REGS_BIT 0

// Fault code field in the partner ability word
`define FAULT_CODE_HI 13
`define FAULT_CODE_LO 12

// Reset values
`define STATUS_RESET 16'h0000

`endif

// File: rtl/status_pkg.sv
package status_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_OPCODE,
        S_ADDRESS,
        S_TURN,
        S_DATA
    } mdio_state_e;

    typedef logic [15:0] status_word_t;

endpackage

// File: rtl/status_latches.sv
`include "status_map.svh"

module status_latches
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Line conditions
    input wire logic sgmii_mode,
    input wire logic loss_of_signal_in,
    input wire logic cdr_lock_lost,
    input wire logic [15:0] partner_ability_word,
    input wire logic pcs_link_up,
    // Read of the status register
    input wire logic read_pulse,
    // Latched bits
    output logic far_end_fault_latch,
    output logic link_up_latch
);

    logic los_q;
    logic los_d;
    logic fault_d;
    logic link_d;
    logic code_fault;
    logic cond_now;
    logic set_evt;

    always_comb begin
        los_d = loss_of_signal_in;
        code_fault = partner_ability_word[`FAULT_CODE_HI:`FAULT_CODE_LO] != 2'h0;
        cond_now = sgmii_mode ? (loss_of_signal_in | cdr_lock_lost) : code_fault;
        set_evt = sgmii_mode ? ((loss_of_signal_in & ~los_q) | cdr_lock_lost) : code_fault;
        fault_d = far_end_fault_latch;
        if (read_pulse) begin
            fault_d = cond_now;
        end
        if (set_evt) begin
            fault_d = 1'b1;
        end
        link_d = link_up_latch;
        if (read_pulse) begin
            link_d = pcs_link_up;
        end
        if (!pcs_link_up) begin
            link_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            los_q <= 1'b0;
            far_end_fault_latch <= 1'b0;
            link_up_latch <= 1'b0;
        end else begin
            los_q <= los_d;
            far_end_fault_latch <= fault_d;
            link_up_latch <= link_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_fault_on_los: assert property (sgmii_mode && loss_of_signal_in && !los_q |=> far_end_fault_latch)
        else $error("Fault bit not set on loss of signal rise");
    chk_fault_on_code: assert property (!sgmii_mode && code_fault |=> far_end_fault_latch)
        else $error("Fault bit not set on fault code");
    chk_fault_read_clear: assert property (read_pulse && !cond_now && !set_evt |=> !far_end_fault_latch)
        else $error("Fault bit not cleared by read");
    chk_fault_holds: assert property (far_end_fault_latch && !read_pulse |=> far_end_fault_latch)
        else $error("Fault bit dropped without read");
    chk_link_drop: assert property (!pcs_link_up |=> !link_up_latch)
        else $error("Link bit not latched low");
    chk_link_read: assert property (read_pulse && pcs_link_up ##0 !link_up_latch |=> link_up_latch)
        else $error("Link bit not restored by read");
    chk_link_holds: assert property (!link_up_latch && !read_pulse |=> !link_up_latch)
        else $error("Link bit rose without read");
    chk_latch_reset: assert property (disable iff (1'b0)
        !resetn |=> !far_end_fault_latch && !link_up_latch)
        else $error("Latched bits not cleared by reset");

endmodule

// File: sim/mdio_station.sv
module mdio_station (
    // Clock and shared line
    input wire logic clock,
    input wire logic line,
    // Master pins
    output logic mdc,
    output logic drive_oe,
    output logic drive_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc = 1'b0;
        drive_oe = 1'b0;
        drive_bit = 1'b1;
    end
    // One frame; mdc idles low between frames, line released for read turnaround and data
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] wd, input int pre, input int half, output logic [15:0] rd);
        logic [31:0] bits;
        bits = {2'h1, op, phy, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = -pre; i < 32; i++) begin
            @(posedge clock);
            drive_oe <= !(op == 2'h2 && i >= 14);
            drive_bit <= (i < 0) ? 1'b1 : bits[31 - i];
            repeat (half) @(posedge clock);
            mdc <= 1'b1;
            if (i >= 16) begin
                rd[31 - i] = line;
            end
            repeat (half) @(posedge clock);
            mdc <= 1'b0;
        end
        drive_oe <= 1'b0;
    endtask
endmodule

// File: sim/basic_mode_status_register_bench.sv
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module basic_mode_status_register_bench
    import status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, resetn = 1'b0, sgmii_mode = 1'b1, los = 1'b0, lol = 1'b0;
    logic pcs_up = 1'b0, neg_done = 1'b0, fault_en = 1'b0, link_en = 1'b0;
    logic [15:0] drive_cycles = 16'h0000;
    logic [15:0] ability = 16'h0000;
    logic [15:0] v;
    logic mdc, m_oe, m_bit, line, mdio_out, mdio_oe, fault_mirror, link_mirror, status_irq;
    int n_fail = 0;
    int total_checks = 0;

    always #12.5 clock = ~clock;
    // Pull-up when nobody drives
    assign line = mdio_oe ? mdio_out : (m_oe ? m_bit : 1'b1);
    always @(posedge clock) begin
        drive_cycles <= drive_cycles + {15'h0000, mdio_oe};
    end

    basic_mode_status_register uut (.clock(clock), .resetn(resetn), .mdc(mdc), .mdio_in(line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_address(5'h05), .sgmii_mode(sgmii_mode),
        .loss_of_signal_in(los), .cdr_lock_lost(lol), .partner_ability_word(ability),
        .pcs_link_up(pcs_up), .negotiation_done_in(neg_done), .fault_irq_enable(fault_en),
        .link_irq_enable(link_en), .fault_mirror(fault_mirror), .link_mirror(link_mirror),
        .status_irq(status_irq));
    mdio_station st (.clock(clock), .line(line), .mdc(mdc), .drive_oe(m_oe), .drive_bit(m_bit));

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    function automatic logic [15:0] word(input logic f, input logic l);
        return 16'h7949 | {10'h000, neg_done, f, 1'b0, l, 2'h0};
    endfunction
    task automatic expect_read(input logic f, input logic l, input int pre);
        st.frame(2'h2, 5'h05, 5'h01, 16'h0000, pre, 2, v);
        tick(3);
        `CHECK(v, word(f, l))
    endtask
    task automatic pulse_los();
        los <= 1'b1;
        tick(1);
        los <= 1'b0;
        tick(3);
    endtask

    task automatic t_reset();
        `CHECK({mdio_oe, fault_mirror, link_mirror, status_irq}, 4'h0)
        expect_read(1'b0, 1'b0, 32);
    endtask
    task automatic t_link();
        pcs_up <= 1'b1;
        tick(2);
        expect_read(1'b0, 1'b0, 0);
        expect_read(1'b0, 1'b1, 0);
        `CHECK(link_mirror, 1'b1)
        link_en <= 1'b1;
        pcs_up <= 1'b0;
        tick(3);
        `CHECK({link_mirror, status_irq}, 2'b01)
        expect_read(1'b0, 1'b0, 0);
        pcs_up <= 1'b1;
        tick(2);
        expect_read(1'b0, 1'b0, 0);
        `CHECK(status_irq, 1'b0)
        expect_read(1'b0, 1'b1, 0);
        pcs_up <= 1'b0;
        tick(1);
        pcs_up <= 1'b1;
        tick(3);
        expect_read(1'b0, 1'b0, 0);
        expect_read(1'b0, 1'b1, 0);
        link_en <= 1'b0;
    endtask
    task automatic t_neg();
        neg_done <= 1'b1;
        tick(2);
        expect_read(1'b0, 1'b1, 0);
        neg_done <= 1'b0;
        tick(2);
        expect_read(1'b0, 1'b1, 0);
    endtask
    task automatic t_sgmii();
        fault_en <= 1'b1;
        pulse_los();
        `CHECK({fault_mirror, status_irq}, 2'b11)
        expect_read(1'b1, 1'b1, 0);
        expect_read(1'b0, 1'b1, 0);
        lol <= 1'b1;
        tick(1);
        lol <= 1'b0;
        tick(3);
        expect_read(1'b1, 1'b1, 0);
        los <= 1'b1;
        tick(3);
        expect_read(1'b1, 1'b1, 0);
        expect_read(1'b1, 1'b1, 0);
        los <= 1'b0;
        tick(2);
        expect_read(1'b1, 1'b1, 0);
        expect_read(1'b0, 1'b1, 0);
        `CHECK(status_irq, 1'b0)
        fault_en <= 1'b0;
    endtask
    task automatic t_basex();
        sgmii_mode <= 1'b0;
        pulse_los();
        expect_read(1'b0, 1'b1, 0);
        for (int c = 0; c < 4; c++) begin
            ability <= {2'h3, c[1:0], 12'hFFF};
            tick(3);
            ability <= 16'h0000;
            tick(2);
            expect_read(c != 0, 1'b1, 0);
            expect_read(1'b0, 1'b1, 0);
        end
        sgmii_mode <= 1'b1;
    endtask
    task automatic t_access();
        logic [15:0] n0;
        n0 = drive_cycles;
        st.frame(2'h1, 5'h05, 5'h01, 16'hFFFF, 0, 2, v);
        tick(3);
        `CHECK(drive_cycles, n0)
        expect_read(1'b0, 1'b1, 0);
        pulse_los();
        st.frame(2'h2, 5'h05, 5'h02, 16'h0000, 0, 2, v);
        tick(3);
        `CHECK(v, 16'h0000)
        n0 = drive_cycles;
        st.frame(2'h2, 5'h06, 5'h01, 16'h0000, 0, 2, v);
        tick(3);
        `CHECK(v, 16'hFFFF)
        `CHECK(drive_cycles, n0)
        st.frame(2'h2, 5'h05, 5'h01, 16'h0000, 32, 5, v);
        tick(3);
        `CHECK(v, word(1'b1, 1'b1))
        expect_read(1'b0, 1'b1, 0);
    endtask
    task automatic t_mid_reset();
        pulse_los();
        `CHECK(fault_mirror, 1'b1)
        resetn <= 1'b0;
        tick(4);
        resetn <= 1'b1;
        tick(2);
        `CHECK({mdio_oe, fault_mirror, link_mirror, status_irq}, 4'h0)
        expect_read(1'b0, 1'b0, 0);
        expect_read(1'b0, 1'b1, 0);
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        resetn <= 1'b1;
        tick(2);
        t_reset();
        t_link();
        t_neg();
        t_sgmii();
        t_basex();
        t_access();
        t_mid_reset();
        final_report();
    end
    initial begin
        tick(40000);
        n_fail++;
        final_report();
    end
endmodule
